// ==== alu_pkg.sv ====
// constants of the eight-bit shift/logic/bit datapath and its apb register map
// assumes a single system clock and an instruction decoder driving op codes
package alu_pkg;

    // ------------------------------------------------------------
    // operation codes presented by the instruction decoder
    // ------------------------------------------------------------
    typedef logic [5:0] op_t;
    localparam op_t OP_SUBC_MEM_ACC = 6'h00;
    localparam op_t OP_SUBC_ACC = 6'h01;
    localparam op_t OP_SUBC_MEM = 6'h02;
    localparam op_t OP_INC_MEM = 6'h03;
    localparam op_t OP_DEC_MEM = 6'h04;
    localparam op_t OP_CLEAR_MEM = 6'h05;
    localparam op_t OP_SHR_ACC = 6'h06;
    localparam op_t OP_SHR_MEM = 6'h07;
    localparam op_t OP_RRC_ACC = 6'h08;
    localparam op_t OP_RRC_MEM = 6'h09;
    localparam op_t OP_SHL_ACC = 6'h0a;
    localparam op_t OP_SHL_MEM = 6'h0b;
    localparam op_t OP_RLC_ACC = 6'h0c;
    localparam op_t OP_RLC_MEM = 6'h0d;
    localparam op_t OP_SWAP_ACC = 6'h0e;
    localparam op_t OP_AND_ACC_IMM = 6'h0f;
    localparam op_t OP_AND_ACC_MEM = 6'h10;
    localparam op_t OP_AND_MEM_ACC = 6'h11;
    localparam op_t OP_OR_ACC_IMM = 6'h12;
    localparam op_t OP_OR_ACC_MEM = 6'h13;
    localparam op_t OP_OR_MEM_ACC = 6'h14;
    localparam op_t OP_XOR_ACC_IMM = 6'h15;
    localparam op_t OP_XOR_ACC_MEM = 6'h16;
    localparam op_t OP_XOR_MEM_ACC = 6'h17;
    localparam op_t OP_XOR_IO_ACC = 6'h18;
    localparam op_t OP_NOT_ACC = 6'h19;
    localparam op_t OP_NOT_MEM = 6'h1a;
    localparam op_t OP_NEG_ACC = 6'h1b;
    localparam op_t OP_NEG_MEM = 6'h1c;
    localparam op_t OP_BCLR_IO = 6'h1d;
    localparam op_t OP_BSET_IO = 6'h1e;
    localparam op_t OP_BCLR_MEM = 6'h1f;
    localparam op_t OP_BSET_MEM = 6'h20;

    // ------------------------------------------------------------
    // flag byte layout
    // ------------------------------------------------------------
    localparam int FLAG_ZERO_BIT = 0;
    localparam int FLAG_CARRY_BIT = 1;
    localparam int FLAG_HALF_BIT = 2;
    localparam int FLAG_SIGNED_BIT = 3;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [7:0] ACC_RESET = 8'h00;

    // ------------------------------------------------------------
    // apb register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_ACC = 8'h04;
    localparam logic [7:0] ADDR_RESULT = 8'h08;
    localparam logic [7:0] ADDR_OP_COUNT = 8'h0c;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam logic [15:0] OP_COUNT_RESET = 16'h0000;
    localparam logic [15:0] OP_COUNT_STEP = 16'h0001;

    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage

// ==== alu_add_sub.sv ====
// eight-bit adder/subtractor with carry, half-carry and signed range flags
// assumes operands are stable while it is read; purely combinational
`timescale 1ns/1ns
`default_nettype none

module alu_add_sub (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    input wire logic sub,
    output logic [7:0] sum,
    output logic carry,
    output logic half,
    output logic ovf
);

    logic [8:0] full;
    logic [4:0] nib;

    // ------------------------------------------------------------
    // sum and flags
    // ------------------------------------------------------------
    always_comb
    begin
        if (sub)
        begin
            // borrow comes out as bit 8 / bit 4 of the wide difference
            full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        end
        else
        begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        end
        sum = full[7:0];
        carry = full[8];
        half = nib[4];
        if (sub)
            ovf = (a[7] != b[7]) && (full[7] != a[7]);
        else
            ovf = (a[7] == b[7]) && (full[7] != a[7]);
    end

endmodule

`default_nettype wire

// ==== shift_logic_alu.sv ====
// eight-bit shift, logic, bit and carry-subtract datapath with apb status port
// assumes the decoder holds op inputs for the cycle op_valid is high,
// and mem_rdata/io_rdata already show the addressed byte in that cycle
//
// Contract
// - mem minus acc minus carry goes back to memory, four flags updated
// - carry alone subtracted from acc or memory, written back, four flags updated
// - increment or decrement memory by one, write back, four flags updated
// - clear writes zero into memory and keeps every flag
// - right shift fills bit 7 with zero, old bit 0 to carry only
// - right rotate puts old carry in bit 7, old bit 0 to carry
// - left shift fills bit 0 with zero, old bit 7 to carry only
// - left rotate puts old carry in bit 0, old bit 7 to carry only
// - swap exchanges acc nibbles, no flag touched
// - and forms write destination and update zero flag only
// - or forms write destination and update zero flag only
// - xor with immediate or memory writes destination, zero flag only
// - xor into io register writes acc xor io, flags kept
// - one's complement inverts operand, zero flag only
// - two's complement negates operand, zero flag only
// - io bit clear or set forces one bit, others and flags kept
// - memory bit clear or set forces one bit, others and flags kept
// - zero flag is one exactly when the eight-bit result is zero
// - carry flag is unsigned carry of add or borrow of subtract
// - half carry is carry or borrow out of the low nibble
// - signed range flag marks two's complement overflow
`timescale 1ns/1ns
`default_nettype none

module shift_logic_alu (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic [5:0] op_code,
    input wire logic [7:0] imm_data,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] io_rdata,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic [7:0] port_a_output_latch,
    output logic io_we,
    output logic [7:0] acc,
    output logic zero_flag,
    output logic carry_flag,
    output logic half_carry_flag,
    output logic signed_range_flag,
    output logic op_done,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ------------------------------------------------------------
    // bit selection mask
    // ------------------------------------------------------------
    logic [7:0] bit_mask;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_mask
            assign bit_mask[gi] = (bit_sel == 3'(gi));
        end
    endgenerate

    // ------------------------------------------------------------
    // shared adder
    // ------------------------------------------------------------
    logic [7:0] add_a;
    logic [7:0] add_b;
    logic add_cin;
    logic add_sub;
    logic [7:0] add_sum;
    logic add_carry;
    logic add_half;
    logic add_ovf;

    alu_add_sub u_add_sub (
        .a(add_a),
        .b(add_b),
        .cin(add_cin),
        .sub(add_sub),
        .sum(add_sum),
        .carry(add_carry),
        .half(add_half),
        .ovf(add_ovf)
    );

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic ctrl_enable;
    logic [7:0] last_result;
    logic [15:0] op_count;
    logic next_ctrl_enable;
    logic [7:0] next_last_result;
    logic [15:0] next_op_count;
    logic [7:0] next_acc;
    logic next_zero_flag;
    logic next_carry_flag;
    logic next_half_carry_flag;
    logic next_signed_range_flag;
    logic [7:0] next_mem_wdata;
    logic next_mem_we;
    logic [7:0] next_port_a_output_latch;
    logic next_io_we;
    logic next_op_done;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    logic accept;
    logic [7:0] res;
    logic to_acc;
    logic to_mem;
    logic to_io;
    logic upd_z;
    logic upd_c;
    logic upd_arith;
    logic c_val;
    logic known;

    assign accept = op_valid && ctrl_enable;

    always_comb
    begin
        res = alu_pkg::BYTE_ZERO;
        to_acc = 1'b0;
        to_mem = 1'b0;
        to_io = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_arith = 1'b0;
        c_val = carry_flag;
        known = 1'b1;
        add_a = mem_rdata;
        add_b = acc;
        add_cin = carry_flag;
        add_sub = 1'b1;
        case (op_code)
            alu_pkg::OP_SUBC_MEM_ACC:
            begin
                res = add_sum;
                to_mem = 1'b1;
                upd_arith = 1'b1;
            end
            alu_pkg::OP_SUBC_ACC:
            begin
                add_a = acc;
                add_b = alu_pkg::BYTE_ZERO;
                res = add_sum;
                to_acc = 1'b1;
                upd_arith = 1'b1;
            end
            alu_pkg::OP_SUBC_MEM:
            begin
                add_b = alu_pkg::BYTE_ZERO;
                res = add_sum;
                to_mem = 1'b1;
                upd_arith = 1'b1;
            end
            alu_pkg::OP_INC_MEM, alu_pkg::OP_DEC_MEM:
            begin
                add_b = alu_pkg::BYTE_ONE;
                add_cin = 1'b0;
                add_sub = (op_code == alu_pkg::OP_DEC_MEM);
                res = add_sum;
                to_mem = 1'b1;
                upd_arith = 1'b1;
            end
            alu_pkg::OP_CLEAR_MEM:
            begin
                res = alu_pkg::BYTE_ZERO;
                to_mem = 1'b1;
            end
            alu_pkg::OP_SHR_ACC, alu_pkg::OP_SHR_MEM:
            begin
                to_acc = (op_code == alu_pkg::OP_SHR_ACC);
                to_mem = !to_acc;
                res = to_acc ? {1'b0, acc[7:1]} : {1'b0, mem_rdata[7:1]};
                c_val = to_acc ? acc[0] : mem_rdata[0];
                upd_c = 1'b1;
            end
            alu_pkg::OP_RRC_ACC, alu_pkg::OP_RRC_MEM:
            begin
                to_acc = (op_code == alu_pkg::OP_RRC_ACC);
                to_mem = !to_acc;
                res = to_acc ? {carry_flag, acc[7:1]} : {carry_flag, mem_rdata[7:1]};
                c_val = to_acc ? acc[0] : mem_rdata[0];
                upd_c = 1'b1;
            end
            alu_pkg::OP_SHL_ACC, alu_pkg::OP_SHL_MEM:
            begin
                to_acc = (op_code == alu_pkg::OP_SHL_ACC);
                to_mem = !to_acc;
                res = to_acc ? {acc[6:0], 1'b0} : {mem_rdata[6:0], 1'b0};
                c_val = to_acc ? acc[7] : mem_rdata[7];
                upd_c = 1'b1;
            end
            alu_pkg::OP_RLC_ACC, alu_pkg::OP_RLC_MEM:
            begin
                to_acc = (op_code == alu_pkg::OP_RLC_ACC);
                to_mem = !to_acc;
                res = to_acc ? {acc[6:0], carry_flag} : {mem_rdata[6:0], carry_flag};
                c_val = to_acc ? acc[7] : mem_rdata[7];
                upd_c = 1'b1;
            end
            alu_pkg::OP_SWAP_ACC:
            begin
                res = {acc[3:0], acc[7:4]};
                to_acc = 1'b1;
            end
            alu_pkg::OP_AND_ACC_IMM:
            begin
                res = acc & imm_data;
                to_acc = 1'b1;
                upd_z = 1'b1;
            end
            alu_pkg::OP_AND_ACC_MEM, alu_pkg::OP_AND_MEM_ACC:
            begin
                res = acc & mem_rdata;
                to_acc = (op_code == alu_pkg::OP_AND_ACC_MEM);
                to_mem = !to_acc;
                upd_z = 1'b1;
            end
            alu_pkg::OP_OR_ACC_IMM:
            begin
                res = acc | imm_data;
                to_acc = 1'b1;
                upd_z = 1'b1;
            end
            alu_pkg::OP_OR_ACC_MEM, alu_pkg::OP_OR_MEM_ACC:
            begin
                res = acc | mem_rdata;
                to_acc = (op_code == alu_pkg::OP_OR_ACC_MEM);
                to_mem = !to_acc;
                upd_z = 1'b1;
            end
            alu_pkg::OP_XOR_ACC_IMM:
            begin
                res = acc ^ imm_data;
                to_acc = 1'b1;
                upd_z = 1'b1;
            end
            alu_pkg::OP_XOR_ACC_MEM, alu_pkg::OP_XOR_MEM_ACC:
            begin
                res = acc ^ mem_rdata;
                to_acc = (op_code == alu_pkg::OP_XOR_ACC_MEM);
                to_mem = !to_acc;
                upd_z = 1'b1;
            end
            alu_pkg::OP_XOR_IO_ACC:
            begin
                res = acc ^ io_rdata;
                to_io = 1'b1;
            end
            alu_pkg::OP_NOT_ACC, alu_pkg::OP_NOT_MEM:
            begin
                to_acc = (op_code == alu_pkg::OP_NOT_ACC);
                to_mem = !to_acc;
                res = to_acc ? ~acc : ~mem_rdata;
                upd_z = 1'b1;
            end
            alu_pkg::OP_NEG_ACC, alu_pkg::OP_NEG_MEM:
            begin
                to_acc = (op_code == alu_pkg::OP_NEG_ACC);
                to_mem = !to_acc;
                // wraps, so negating 0x80 gives 0x80 back
                res = alu_pkg::BYTE_ZERO - (to_acc ? acc : mem_rdata);
                upd_z = 1'b1;
            end
            alu_pkg::OP_BCLR_IO, alu_pkg::OP_BSET_IO:
            begin
                res = (op_code == alu_pkg::OP_BSET_IO) ? (io_rdata | bit_mask)
                                                       : (io_rdata & ~bit_mask);
                to_io = 1'b1;
            end
            alu_pkg::OP_BCLR_MEM, alu_pkg::OP_BSET_MEM:
            begin
                res = (op_code == alu_pkg::OP_BSET_MEM) ? (mem_rdata | bit_mask)
                                                        : (mem_rdata & ~bit_mask);
                to_mem = 1'b1;
            end
            default:
            begin
                // unknown codes are dropped without any side effect
                known = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic bus_access;
    logic bus_commit;
    logic addr_hit;

    assign bus_access = psel && penable && !pready;
    assign bus_commit = psel && penable && pready && pwrite && !pslverr;

    always_comb
    begin
        addr_hit = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            alu_pkg::ADDR_FLAGS:
            begin
                next_prdata[alu_pkg::FLAG_ZERO_BIT] = zero_flag;
                next_prdata[alu_pkg::FLAG_CARRY_BIT] = carry_flag;
                next_prdata[alu_pkg::FLAG_HALF_BIT] = half_carry_flag;
                next_prdata[alu_pkg::FLAG_SIGNED_BIT] = signed_range_flag;
            end
            alu_pkg::ADDR_ACC: next_prdata[7:0] = acc;
            alu_pkg::ADDR_RESULT: next_prdata[7:0] = last_result;
            alu_pkg::ADDR_OP_COUNT: next_prdata[15:0] = op_count;
            alu_pkg::ADDR_CTRL: next_prdata[alu_pkg::CTRL_ENABLE_BIT] = ctrl_enable;
            default: addr_hit = 1'b0;
        endcase
        if (!bus_access)
            next_prdata = prdata;
        next_pready = bus_access;
        // error flagged in the cycle pready rises, so the write is dropped
        next_pslverr = bus_access && !addr_hit;
    end

    // ------------------------------------------------------------
    // next state of datapath and registers
    // ------------------------------------------------------------
    logic fire;
    logic sw_wr_low;

    assign fire = accept && known;
    assign sw_wr_low = bus_commit && pstrb[0];

    always_comb
    begin
        next_ctrl_enable = ctrl_enable;
        next_acc = acc;
        next_zero_flag = zero_flag;
        next_carry_flag = carry_flag;
        next_half_carry_flag = half_carry_flag;
        next_signed_range_flag = signed_range_flag;
        next_last_result = last_result;
        next_op_count = op_count;
        // software writes first, so a datapath update in the same cycle wins
        if (sw_wr_low && paddr == alu_pkg::ADDR_FLAGS)
        begin
            next_zero_flag = pwdata[alu_pkg::FLAG_ZERO_BIT];
            next_carry_flag = pwdata[alu_pkg::FLAG_CARRY_BIT];
            next_half_carry_flag = pwdata[alu_pkg::FLAG_HALF_BIT];
            next_signed_range_flag = pwdata[alu_pkg::FLAG_SIGNED_BIT];
        end
        if (sw_wr_low && paddr == alu_pkg::ADDR_ACC)
            next_acc = pwdata[7:0];
        if (sw_wr_low && paddr == alu_pkg::ADDR_CTRL)
            next_ctrl_enable = pwdata[alu_pkg::CTRL_ENABLE_BIT];
        if (fire)
        begin
            next_last_result = res;
            next_op_count = op_count + alu_pkg::OP_COUNT_STEP;
            if (to_acc)
                next_acc = res;
            if (upd_arith || upd_z)
                next_zero_flag = (res == alu_pkg::BYTE_ZERO);
            if (upd_arith)
            begin
                next_carry_flag = add_carry;
                next_half_carry_flag = add_half;
                next_signed_range_flag = add_ovf;
            end
            if (upd_c)
                next_carry_flag = c_val;
        end
        next_mem_we = fire && to_mem;
        next_io_we = fire && to_io;
        next_mem_wdata = (fire && to_mem) ? res : mem_wdata;
        next_port_a_output_latch = (fire && to_io) ? res : port_a_output_latch;
        next_op_done = fire;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_enable <= alu_pkg::CTRL_ENABLE_RESET;
            acc <= alu_pkg::ACC_RESET;
            zero_flag <= alu_pkg::FLAGS_RESET[alu_pkg::FLAG_ZERO_BIT];
            carry_flag <= alu_pkg::FLAGS_RESET[alu_pkg::FLAG_CARRY_BIT];
            half_carry_flag <= alu_pkg::FLAGS_RESET[alu_pkg::FLAG_HALF_BIT];
            signed_range_flag <= alu_pkg::FLAGS_RESET[alu_pkg::FLAG_SIGNED_BIT];
            last_result <= alu_pkg::BYTE_ZERO;
            op_count <= alu_pkg::OP_COUNT_RESET;
            mem_wdata <= alu_pkg::BYTE_ZERO;
            mem_we <= 1'b0;
            port_a_output_latch <= alu_pkg::BYTE_ZERO;
            io_we <= 1'b0;
            op_done <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            ctrl_enable <= next_ctrl_enable;
            acc <= next_acc;
            zero_flag <= next_zero_flag;
            carry_flag <= next_carry_flag;
            half_carry_flag <= next_half_carry_flag;
            signed_range_flag <= next_signed_range_flag;
            last_result <= next_last_result;
            op_count <= next_op_count;
            mem_wdata <= next_mem_wdata;
            mem_we <= next_mem_we;
            port_a_output_latch <= next_port_a_output_latch;
            io_we <= next_io_we;
            op_done <= next_op_done;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

endmodule

`default_nettype wire

// ==== data_mem_model.sv ====
// addressed data memory byte and io register beside the datapath
// assumes one byte each; load presets both before a sequence
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
    input wire logic clk_sys,
    input wire logic load,
    input wire logic [7:0] load_data,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    input wire logic io_we,
    input wire logic [7:0] io_wdata,
    output logic [7:0] mem_rdata,
    output logic [7:0] io_rdata
);
    // written byte shows one edge later, as a real memory would
    always @(posedge clk_sys)
    begin
        if (load || mem_we)
            mem_rdata <= load ? load_data : mem_wdata;
        if (load || io_we)
            io_rdata <= load ? load_data : io_wdata;
    end
endmodule
`default_nettype wire

// ==== shift_logic_alu_monitor.sv ====
// assertions on the datapath outputs against the op taken one edge before
// assumes binding to shift_logic_alu, single clock domain
`timescale 1ns/1ns
`default_nettype none
module shift_logic_alu_monitor (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic [5:0] op_code,
    input wire logic [7:0] imm_data,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] io_rdata,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic [7:0] port_a_output_latch,
    input wire logic io_we,
    input wire logic [7:0] acc,
    input wire logic zero_flag,
    input wire logic carry_flag,
    input wire logic half_carry_flag,
    input wire logic signed_range_flag,
    input wire logic op_done
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property after_op(c, p);
        op_done && $past(op_valid) && $past(op_code) == c |-> p;
    endproperty
    clear_keeps_a: assert property (after_op(alu_pkg::OP_CLEAR_MEM, mem_we && mem_wdata == 8'h00 &&
        $stable({zero_flag, carry_flag, half_carry_flag, signed_range_flag}))) else $error("clear wrong");
    shr_acc_a: assert property (after_op(alu_pkg::OP_SHR_ACC, acc == {1'b0, $past(acc[7:1])} &&
        carry_flag == $past(acc[0]) && $stable(zero_flag))) else $error("right shift wrong");
    rlc_acc_a: assert property (after_op(alu_pkg::OP_RLC_ACC, acc == {$past(acc[6:0]), $past(carry_flag)} &&
        carry_flag == $past(acc[7]))) else $error("left rotate wrong");
    swap_acc_a: assert property (after_op(alu_pkg::OP_SWAP_ACC,
        acc == {$past(acc[3:0]), $past(acc[7:4])} && $stable(carry_flag))) else $error("swap wrong");
    xor_io_a: assert property (after_op(alu_pkg::OP_XOR_IO_ACC,
        io_we && port_a_output_latch == $past(acc ^ io_rdata))) else $error("io xor wrong");
    bit_set_a: assert property (after_op(alu_pkg::OP_BSET_MEM,
        mem_wdata == ($past(mem_rdata) | (8'h01 << $past(bit_sel))))) else $error("bit set wrong");
    inc_mem_a: assert property (after_op(alu_pkg::OP_INC_MEM, mem_wdata == $past(mem_rdata) + 8'h01 &&
        carry_flag == ($past(mem_rdata) == 8'hff))) else $error("increment wrong");
    and_zero_a: assert property (after_op(alu_pkg::OP_AND_ACC_IMM, acc == $past(acc & imm_data) &&
        zero_flag == (acc == 8'h00))) else $error("and zero flag wrong");
    cover property (op_done && mem_we);
    cover property (op_done && io_we);
    cover property (op_done && zero_flag && carry_flag);
endmodule
bind shift_logic_alu shift_logic_alu_monitor u_shift_logic_alu_monitor (.clk_sys, .rst, .op_valid, .op_code,
    .imm_data, .bit_sel, .mem_rdata, .io_rdata, .mem_wdata, .mem_we, .port_a_output_latch, .io_we, .acc,
    .zero_flag, .carry_flag, .half_carry_flag, .signed_range_flag, .op_done);
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench: op chain from a table, apb access, refused op
// assumes the memory model shows a written byte one edge later
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0;
    logic load = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [5:0] op_code = 6'h00;
    logic [7:0] imm_data = 8'h00;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic [7:0] mem_rdata, io_rdata, mem_wdata, port_a_output_latch, acc;
    logic pready, pslverr, er, mem_we, io_we, op_done;
    logic zero_flag, carry_flag, half_carry_flag, signed_range_flag;
    int err_count = 0;
    int comparisons = 0;
    // row: op, imm/bit, result, flags {ov,half,carry,zero}, dest 0 acc 1 mem 2 io 3 load + unknown op
    logic [31:0] tab [38] = '{32'hff810003, 32'h06004020, 32'h0e000420, 32'h0ff00030, 32'h125a5a20,
        32'h155a0030, 32'h1900ff20, 32'h1b000120, 32'h10000120, 32'h13008120, 32'h11008121, 32'h17000031,
        32'h14008121, 32'h18000022, 32'h1e030822, 32'h1d030022, 32'h20018321, 32'h1f008221, 32'h16000320,
        32'h08008120, 32'h0c000320, 32'h0a000600, 32'h07004101, 32'h09002021, 32'h0b004001, 32'h0d008001,
        32'h1a007f01, 32'h1c008101, 32'h00007bc1, 32'hffff0003, 32'h03000071, 32'h01000500, 32'h0400ff61,
        32'h0200fe01, 32'hff800003, 32'h04007fc1, 32'h050000c1, 32'h0000fb61};
    always #50 clk_sys = ~clk_sys;
    shift_logic_alu u_shift_logic_alu (.clk_sys, .rst, .op_valid, .op_code, .imm_data, .bit_sel(imm_data[2:0]),
        .mem_rdata, .io_rdata, .mem_wdata, .mem_we, .port_a_output_latch, .io_we, .acc, .zero_flag,
        .carry_flag, .half_carry_flag, .signed_range_flag, .op_done, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr);
    data_mem_model u_data_mem_model (.clk_sys, .load, .load_data(imm_data), .mem_we, .mem_wdata, .io_we,
        .io_wdata(port_a_output_latch), .mem_rdata, .io_rdata);
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task test_done;
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task check(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // read just after the edge, so the values are those sampled there
    task apb(input logic w, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge clk_sys);
        if (n == 20)
        begin
            err_count++;
            test_done;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rows(input int lo, hi);
        for (int i = lo; i <= hi; i++)
        begin
            @(posedge clk_sys);
            imm_data <= tab[i][23:16];
            op_code <= tab[i][29:24];
            op_valid <= 1'b1;
            load <= tab[i][3:0] == 4'h3;
            @(posedge clk_sys);
            op_valid <= 1'b0;
            load <= 1'b0;
            @(negedge clk_sys);
            if (tab[i][3:0] != 4'h3)
            begin
                check(tab[i][0] ? mem_wdata : tab[i][1] ? port_a_output_latch : acc, tab[i][15:8]);
                check({signed_range_flag, half_carry_flag, carry_flag, zero_flag}, tab[i][7:4]);
            end
            check({mem_we, io_we, op_done}, tab[i][3:0] == 4'h3 ? 32'h0 : {tab[i][0], tab[i][1], 1'b1});
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task sc_regs;
        apb(1'b0, alu_pkg::ADDR_CTRL, 32'h0);
        check(rd, 32'h1);
        apb(1'b1, alu_pkg::ADDR_ACC, 32'h81);
        apb(1'b1, alu_pkg::ADDR_FLAGS, 32'h0);
        apb(1'b0, alu_pkg::ADDR_ACC, 32'h0);
        check(rd, 32'h81);
        apb(1'b1, 8'h40, 32'hff);
        check({31'h0, er}, 32'h1);
    endtask
    task sc_refused;
        apb(1'b1, alu_pkg::ADDR_CTRL, 32'h0);
        @(posedge clk_sys);
        op_code <= alu_pkg::OP_NOT_ACC;
        op_valid <= 1'b1;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        @(negedge clk_sys);
        check({op_done, acc}, {1'b0, 8'h05});
        apb(1'b1, alu_pkg::ADDR_CTRL, 32'h1);
    endtask
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        sc_regs;
        rows(0, 18);
        rows(19, 28);
        rows(29, 37);
        sc_refused;
        test_done;
    end
endmodule
`default_nettype wire
